/* hdl/rbs_map.svh */
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
`define RBS_ADDR_W          8
`define RBS_DATA_W          32
`define RBS_CTRL_OFS        8'h00
`define RBS_STATUS_OFS      8'h04
`define RBS_SWEN_BIT        7
`define RBS_FS_BIT          6
`define RBS_RDY_BIT         0
`define RBS_SWEN_RST        1'b1
`define RBS_FS_RST          1'b0
`define RBS_ST_LSB          0
`define RBS_ST_MSB          7
`define RBS_STAT_RST_BIT    8
`define RBS_STAT_PROT_BIT   9
`define RBS_STAT_EN_BIT     10
`define RBS_RESP_OKAY       2'h0
`define RBS_RESP_SLVERR     2'h2
`define RBS_CLK_PERIOD_NS   50
`define RBS_CLK_MHZ         20
`define RBS_PUT_TIME_US     64000
`define RBS_PUT_CYCLES      (`RBS_PUT_TIME_US * `RBS_CLK_MHZ)
`define RBS_PUT_W           21
`define RBS_FILT_TIME_NS    1000
`define RBS_FILT_CYCLES     ((`RBS_FILT_TIME_NS + `RBS_CLK_PERIOD_NS - 1) / `RBS_CLK_PERIOD_NS)
`define RBS_FILT_W          8
`define RBS_EXEC_DELAY      10
`define RBS_DLY_W           4
`endif

/* hdl/rbs_pkg.sv */
`include "rbs_map.svh"
package rbs_pkg;
  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_SW      = 2'h1,
    MODE_NOSLEEP = 2'h2,
    MODE_ON      = 2'h3
  } rbs_mode_t;

  typedef enum logic [7:0] {
    ST_POR   = 8'h01,
    ST_PUT   = 8'h02,
    ST_WAIT  = 8'h04,
    ST_PIN   = 8'h08,
    ST_DELAY = 8'h10,
    ST_RUN   = 8'h20,
    ST_SLEEP = 8'h40,
    ST_WAKE  = 8'h80
  } rbs_state_t;

  typedef struct packed {
    rbs_state_t              st;
    logic [`RBS_PUT_W-1:0]   put_cnt;
    logic [`RBS_FILT_W-1:0]  filt_cnt;
    logic [`RBS_DLY_W-1:0]   dly_cnt;
    logic                    sw_en;
    logic                    fast_start;
    logic                    circ_en_out;
    logic                    bandgap_out;
    logic                    level_out;
    logic                    aw_got;
    logic [`RBS_ADDR_W-1:0]  aw_addr;
    logic                    w_got;
    logic [`RBS_DATA_W-1:0]  w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [`RBS_DATA_W-1:0]  rdata;
    logic [1:0]              rresp;
  } rbs_regs_t;
endpackage : rbs_pkg

/* hdl/rbs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rbs_map.svh"
module rbs_sequencer #(
  parameter int unsigned PUT_CYCLES = `RBS_PUT_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  input  wire logic                     por_active,
  input  wire logic                     brownout_below,
  input  wire logic                     brownout_circuit_ready_in,
  input  wire logic                     low_power_brownout_req,
  input  wire logic                     external_reset_pin_n,
  input  wire logic                     pin_reset_en,
  input  wire logic                     watchdog_timer_reset,
  input  wire logic                     reset_instr,
  input  wire logic                     stack_overflow,
  input  wire logic                     stack_underflow,
  input  wire logic                     stack_reset_en,
  input  wire logic                     prog_mode_exit,
  input  wire logic                     powerup_timer_enable_n,
  input  wire rbs_pkg::rbs_mode_t       brownout_mode_select,
  input  wire logic                     brownout_level_select,
  input  wire logic                     osc_startup_done,
  input  wire logic                     sleep_active,
  output logic                          chip_reset,
  output logic                          cpu_exec_enable,
  output logic                          brownout_circuit_enable,
  output logic                          brownout_threshold_sel,
  output logic                          bandgap_force_on,
  input  wire logic [`RBS_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [`RBS_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`RBS_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [`RBS_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  import rbs_pkg::*;

  localparam logic [`RBS_FILT_W-1:0] FILT_LAST = `RBS_FILT_W'(`RBS_FILT_CYCLES);
  localparam logic [`RBS_PUT_W-1:0]  PUT_LAST  = `RBS_PUT_W'(PUT_CYCLES - 1);
  localparam logic [`RBS_DLY_W-1:0]  DLY_LAST  = `RBS_DLY_W'(`RBS_EXEC_DELAY - 1);

  // modes in which the configuration forces the circuit on at start-up
  function automatic logic mode_forced(input rbs_mode_t m);
    return (m == MODE_ON) || (m == MODE_NOSLEEP);
  endfunction : mode_forced

  // whether the brown-out circuit is switched on at all
  function automatic logic mode_active(input rbs_mode_t m, input logic slp, input logic swe);
    logic a;
    a = 1'b0;
    unique case (m)
      MODE_ON:      a = 1'b1;
      MODE_NOSLEEP: a = !slp;
      MODE_SW:      a = swe;
      MODE_OFF:     a = 1'b0;
    endcase
    return a;
  endfunction : mode_active

  rbs_regs_t r_r;
  rbs_regs_t r_nxt;

  logic bo_on;
  logic prot;
  logic bo_hold;
  logic pin_act;
  logic pulse_src;
  logic pwr_src;
  logic start_ok;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // protection only bites once the analog side says it is up
  assign bo_on     = mode_active(brownout_mode_select, sleep_active, r_r.sw_en);
  assign prot      = bo_on && brownout_circuit_ready_in;
  // short dips never reach the counter's end, so they never reset
  assign bo_hold   = prot && brownout_below && (r_r.filt_cnt == FILT_LAST);
  assign pwr_src   = por_active || bo_hold || low_power_brownout_req
                     || prog_mode_exit;
  assign pin_act   = pin_reset_en && !external_reset_pin_n;
  assign pulse_src = watchdog_timer_reset || reset_instr
                     || (stack_reset_en && (stack_overflow || stack_underflow));
  assign start_ok  = osc_startup_done
                     && (!mode_forced(brownout_mode_select)
                         || (brownout_circuit_ready_in && !brownout_below));

  // sources act without waiting for a clock; release waits for the state machine
  assign chip_reset = pwr_src || pin_act || pulse_src
                      || (r_r.st inside {ST_POR, ST_PUT, ST_WAIT, ST_PIN, ST_DELAY});
  assign cpu_exec_enable = (r_r.st == ST_RUN) && !chip_reset;

  assign brownout_circuit_enable = r_r.circ_en_out;
  assign brownout_threshold_sel  = r_r.level_out;
  assign bandgap_force_on        = r_r.bandgap_out;

  assign s_axi_awready = clk_en && !r_r.aw_got && !r_r.bvalid;
  assign s_axi_wready  = clk_en && !r_r.w_got && !r_r.bvalid;
  assign s_axi_arready = clk_en && !r_r.rvalid;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rdata   = r_r.rdata;
  assign s_axi_rresp   = r_r.rresp;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb begin
    r_nxt = r_r;
    // analog controls are registered to keep them glitch free
    r_nxt.circ_en_out = bo_on;
    r_nxt.level_out   = brownout_level_select;
    // fast start is ignored in the always-on (MODE_ON) and the off modes
    r_nxt.bandgap_out = 1'b0;
    if ((brownout_mode_select == MODE_NOSLEEP) || (brownout_mode_select == MODE_SW)) begin
      r_nxt.bandgap_out = r_r.fast_start;
    end

    if (prot && brownout_below) begin
      if (r_r.filt_cnt != FILT_LAST) begin
        r_nxt.filt_cnt = r_r.filt_cnt + 1'b1;
      end
    end else begin
      r_nxt.filt_cnt = '0;
    end

    if (pwr_src) begin
      r_nxt.st = ST_POR;
    end else if (pulse_src) begin
      r_nxt.st = ST_WAIT;
    end else if (pin_act && !(r_r.st inside {ST_POR, ST_PUT})) begin
      r_nxt.st = ST_PIN;
    end else begin
      unique case (r_r.st)
        ST_POR: begin
          r_nxt.put_cnt = '0;
          r_nxt.st = powerup_timer_enable_n ? ST_WAIT : ST_PUT;
        end
        ST_PUT: begin
          // the pin does not stop this count
          if (r_r.put_cnt == PUT_LAST) begin
            r_nxt.st = ST_WAIT;
          end else begin
            r_nxt.put_cnt = r_r.put_cnt + 1'b1;
          end
        end
        ST_WAIT: begin
          if (start_ok) begin
            r_nxt.st = ST_RUN;
          end
        end
        ST_PIN: begin
          if (start_ok) begin
            r_nxt.st = ST_DELAY;
            r_nxt.dly_cnt = `RBS_DLY_W'(1);
          end else begin
            r_nxt.st = ST_WAIT;
          end
        end
        ST_DELAY: begin
          if (r_r.dly_cnt == DLY_LAST) begin
            r_nxt.st = ST_RUN;
          end else begin
            r_nxt.dly_cnt = r_r.dly_cnt + 1'b1;
          end
        end
        ST_RUN: begin
          if (sleep_active) begin
            r_nxt.st = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!sleep_active) begin
            r_nxt.st = (brownout_mode_select == MODE_NOSLEEP) ? ST_WAKE : ST_RUN;
          end
        end
        ST_WAKE: begin
          if (brownout_circuit_ready_in) begin
            r_nxt.st = ST_RUN;
          end
        end
        default: r_nxt.st = ST_POR;
      endcase
    end

    // register bus: address and data may arrive in either order
    if (aw_hs) begin
      r_nxt.aw_got  = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      r_nxt.w_got  = 1'b1;
      r_nxt.w_data = s_axi_wdata;
      r_nxt.w_strb = s_axi_wstrb;
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = `RBS_RESP_OKAY;
      if (r_r.aw_addr == `RBS_CTRL_OFS) begin
        if (r_r.w_strb[0]) begin
          r_nxt.sw_en      = r_r.w_data[`RBS_SWEN_BIT];
          r_nxt.fast_start = r_r.w_data[`RBS_FS_BIT];
        end
      end else if (r_r.aw_addr != `RBS_STATUS_OFS) begin
        r_nxt.bresp = `RBS_RESP_SLVERR;
      end
    end
    // power-on, brown-out and programming-mode exit reload the control bits; pin, watchdog, instruction and stack resets leave them
    if (r_r.st == ST_POR) begin
      r_nxt.sw_en      = `RBS_SWEN_RST;
      r_nxt.fast_start = `RBS_FS_RST;
    end

    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = `RBS_RESP_OKAY;
      r_nxt.rdata  = '0;
      if (s_axi_araddr == `RBS_CTRL_OFS) begin
        r_nxt.rdata[`RBS_SWEN_BIT] = r_r.sw_en;
        r_nxt.rdata[`RBS_FS_BIT]   = r_r.fast_start;
        r_nxt.rdata[`RBS_RDY_BIT]  = brownout_circuit_ready_in;
      end else if (s_axi_araddr == `RBS_STATUS_OFS) begin
        r_nxt.rdata[`RBS_ST_MSB:`RBS_ST_LSB] = r_r.st;
        r_nxt.rdata[`RBS_STAT_RST_BIT]       = chip_reset;
        r_nxt.rdata[`RBS_STAT_PROT_BIT]      = prot;
        r_nxt.rdata[`RBS_STAT_EN_BIT]        = bo_on;
      end else begin
        r_nxt.rresp = `RBS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_r            <= '0;
      r_r.st         <= ST_POR;
      r_r.sw_en      <= `RBS_SWEN_RST;
      r_r.fast_start <= `RBS_FS_RST;
    end else if (clk_en) begin
      r_r <= r_nxt;
    end
  end

  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (reset);

  sequence s_pin_release;
    (r_r.st == ST_PIN) && !pin_act && !pwr_src && !pulse_src && start_ok;
  endsequence
  sequence s_delay_run;
    (r_r.st == ST_DELAY)[*8] ##1 (r_r.st == ST_DELAY) ##1 (r_r.st == ST_RUN);
  endsequence
  sequence s_wait_to_run;
    (r_r.st == ST_WAIT) && mode_forced(brownout_mode_select) ##1 (r_r.st == ST_RUN);
  endsequence

  a_por_holds_reset: assert property (por_active |-> chip_reset && !cpu_exec_enable)
    else $error("power-on did not hold reset");
  a_put_holds_reset: assert property ((r_r.st == ST_PUT) |-> chip_reset)
    else $error("reset released while power-up timer runs");
  a_put_start_gate: assert property ($rose(r_r.st == ST_PUT) |->
      $past(r_r.st == ST_POR) && !$past(pwr_src) && !$past(powerup_timer_enable_n))
    else $error("power-up timer started wrongly");
  a_bo_hold_reset: assert property (bo_hold |-> chip_reset ##1 (r_r.st == ST_POR))
    else $error("brown-out did not hold reset");
  a_bo_filter_len: assert property ($rose(bo_hold) |-> $past(prot && brownout_below))
    else $error("brown-out tripped without a long dip");
  a_mode_off_quiet: assert property ((brownout_mode_select == MODE_OFF) |->
      !prot ##1 !brownout_circuit_enable)
    else $error("brown-out active in off mode");
  a_sleep_prot_off: assert property ((brownout_mode_select == MODE_NOSLEEP)
      && sleep_active |-> !prot)
    else $error("protection on during sleep");
  a_sw_mode_enable: assert property ((brownout_mode_select == MODE_SW) |->
      (bo_on == r_r.sw_en))
    else $error("software enable not followed");
  a_fast_start_gate: assert property (bandgap_force_on |->
      $past(brownout_mode_select == MODE_NOSLEEP || brownout_mode_select == MODE_SW))
    else $error("band gap forced in wrong mode");
  a_ctrl_reload: assert property ((r_r.st == ST_POR) |=> r_r.sw_en && !r_r.fast_start)
    else $error("control bits not reloaded");
  a_pin_delay_ten: assert property (s_pin_release |-> ##1 s_delay_run)
    else $error("pin release delay is not ten cycles");
  a_start_ready: assert property (s_wait_to_run |->
      $past(brownout_circuit_ready_in && !brownout_below))
    else $error("forced mode started before ready");
endmodule : rbs_sequencer
`default_nettype wire

/* dv/rbs_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rbs_supply_model #(
  parameter int RDY_DLY = 4,
  parameter int OSC_DLY = 6
) (
  input  wire logic clk,
  input  wire logic supply_low,
  input  wire logic dip,
  input  wire logic lp_req,
  input  wire logic pin_hold,
  input  wire logic circuit_en,
  output logic      por_active,
  output logic      brownout_below,
  output logic      circuit_ready,
  output logic      lp_bo_req,
  output logic      pin_n,
  output logic      osc_done
);
  int rdy_cnt = 0;
  int osc_cnt = 0;
  assign por_active = supply_low;
  assign brownout_below = dip;
  assign lp_bo_req = lp_req;
  // weak pull-up on the pin: a released pin reads high
  assign pin_n = !pin_hold;
  // the circuit is slow to wake, so ready lags its enable
  assign circuit_ready = circuit_en && (rdy_cnt >= RDY_DLY);
  assign osc_done = (osc_cnt >= OSC_DLY);
  always @(posedge clk) begin
    rdy_cnt <= (circuit_en !== 1'b1) ? 0 : ((rdy_cnt < RDY_DLY) ? rdy_cnt + 1 : rdy_cnt);
    osc_cnt <= supply_low ? 0 : ((osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt);
  end
endmodule : rbs_supply_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rbs_pkg::*;
  localparam int PUT_LEN = 20;
  logic clk = 1'b0, reset = 1'b1, supply_low = 1'b0, dip = 1'b0, pin_hold = 1'b0;
  logic [5:0] src = 6'h00;
  logic put_n = 1'b0, level = 1'b0, sleep = 1'b0;
  logic [1:0] mode = 2'h3;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic por, below, rdy_in, lp_bo, pin_n, osc_done, chip_reset, cpu_exec, circ_en;
  wire logic thr_sel, bg_on, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int failures = 0, comparisons = 0, cycles = 0, n;
  logic [31:0] d;
  logic [1:0] r;
  logic ok;
  rbs_supply_model u_supply (.clk(clk), .supply_low(supply_low), .dip(dip), .lp_req(src[5]),
    .pin_hold(pin_hold), .circuit_en(circ_en), .por_active(por), .brownout_below(below),
    .circuit_ready(rdy_in), .lp_bo_req(lp_bo), .pin_n(pin_n), .osc_done(osc_done));
  rbs_sequencer #(.PUT_CYCLES(PUT_LEN)) u_dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .por_active(por), .brownout_below(below), .brownout_circuit_ready_in(rdy_in),
    .low_power_brownout_req(lp_bo), .external_reset_pin_n(pin_n), .pin_reset_en(1'b1),
    .watchdog_timer_reset(src[0]), .reset_instr(src[1]), .stack_overflow(src[2]),
    .stack_underflow(src[3]), .stack_reset_en(1'b1), .prog_mode_exit(src[4]),
    .powerup_timer_enable_n(put_n), .brownout_mode_select(rbs_mode_t'(mode)),
    .brownout_level_select(level), .osc_startup_done(osc_done), .sleep_active(sleep),
    .chip_reset(chip_reset), .cpu_exec_enable(cpu_exec), .brownout_circuit_enable(circ_en),
    .brownout_threshold_sel(thr_sel), .bandgap_force_on(bg_on),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // ceiling sits far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ta, tw, da, dw, bv;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge clk);
      if (ta) begin
        da = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        dw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      bv = bvalid;
      resp = bresp;
      @(posedge clk);
    end while (bv !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ta, rv;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arready;
      @(posedge clk);
    end while (ta !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      rv = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
    end while (rv !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_run(input int lim);
    n = 0;
    @(negedge clk);
    while (cpu_exec !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(cpu_exec, 1'b1, "cpu start");
  endtask : wait_run
  task automatic hold_check(input string what);
    ok = 1'b1;
    repeat (PUT_LEN) begin
      @(negedge clk);
      ok &= (chip_reset === 1'b1);
    end
    chk(ok, 1'b1, what);
  endtask : hold_check
  task automatic test_powerup();
    hold_check("timer hold");
    wait_run(200);
    @(posedge clk) put_n <= 1'b1;
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    wait_run(200);
    chk(n < PUT_LEN, 1'b1, "timer off");
    put_n <= 1'b0;
    $display("powerup done");
  endtask : test_powerup
  task automatic test_regs();
    axi_rd(8'h00, d, r);
    chk(d, 32'h81, "ctrl reset");
    axi_wr(8'h00, 32'hFF, r);
    axi_rd(8'h00, d, r);
    chk(d, 32'hC1, "ctrl rw");
    axi_rd(8'h08, d, r);
    chk(r, 2'h2, "bad read");
    axi_wr(8'h0C, 32'h0, r);
    chk(r, 2'h2, "bad write");
    axi_wr(8'h04, 32'h0, r);
    chk(r, 2'h0, "status write");
    axi_wr(8'h00, 32'h80, r);
    $display("regs done");
  endtask : test_regs
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= m[1:0];
      axi_wr(8'h00, 32'hC0, r);
      repeat (3) @(negedge clk);
      chk(circ_en, m != 0, "mode enable");
      chk(bg_on, m == 1 || m == 2, "fast start");
    end
    @(posedge clk) mode <= 2'h1;
    axi_wr(8'h00, 32'h00, r);
    repeat (8) @(negedge clk);
    chk(circ_en, 1'b0, "sw off");
    axi_rd(8'h00, d, r);
    chk(d, 32'h00, "ready off");
    level <= 1'b1;
    mode <= 2'h3;
    axi_wr(8'h00, 32'h80, r);
    repeat (10) @(negedge clk);
    chk(thr_sel, 1'b1, "level");
    $display("modes done");
  endtask : test_modes
  task automatic test_filter();
    @(posedge clk) dip <= 1'b1;
    ok = 1'b1;
    repeat (10) begin
      @(negedge clk);
      ok &= (chip_reset === 1'b0);
    end
    @(posedge clk) dip <= 1'b0;
    chk(ok, 1'b1, "short dip");
    repeat (5) @(posedge clk);
    dip <= 1'b1;
    repeat (40) @(negedge clk);
    chk(chip_reset, 1'b1, "long dip");
    @(posedge clk) dip <= 1'b0;
    hold_check("timer after dip");
    wait_run(200);
    $display("filter done");
  endtask : test_filter
  task automatic test_pin();
    @(posedge clk) pin_hold <= 1'b1;
    repeat (5) @(negedge clk);
    chk(chip_reset, 1'b1, "pin reset");
    // the pin rises after this edge; the tenth edge later starts execution
    @(posedge clk) pin_hold <= 1'b0;
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk(cpu_exec, 1'b0, "pin early");
    @(negedge clk);
    chk(cpu_exec, 1'b1, "pin tenth");
    $display("pin done");
  endtask : test_pin
  task automatic test_sources();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) src <= 6'h01 << i;
      @(negedge clk);
      chk(chip_reset, 1'b1, "source");
      @(posedge clk) src <= 6'h00;
      wait_run(200);
    end
    $display("sources done");
  endtask : test_sources
  task automatic test_off_mode();
    @(posedge clk) mode <= 2'h0;
    repeat (10) @(posedge clk);
    src <= 6'h01;
    @(posedge clk) src <= 6'h00;
    wait_run(200);
    chk(n < 4 && rdy_in === 1'b0, 1'b1, "off start");
    mode <= 2'h3;
    repeat (10) @(posedge clk);
    $display("off mode done");
  endtask : test_off_mode
  task automatic test_por();
    axi_wr(8'h00, 32'h40, r);
    @(posedge clk) supply_low <= 1'b1;
    repeat (10) @(negedge clk);
    chk(chip_reset, 1'b1, "supply low");
    @(posedge clk) supply_low <= 1'b0;
    hold_check("timer after supply");
    wait_run(200);
    axi_rd(8'h00, d, r);
    chk(d, 32'h81, "ctrl reload");
    $display("power-on done");
  endtask : test_por
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    test_powerup();
    test_regs();
    test_modes();
    test_filter();
    test_pin();
    test_sources();
    test_off_mode();
    test_por();
    results();
  end
endmodule : testbench
`default_nettype wire
